/* File: rtl/sixteen_bit_timer_with_osc.sv */
// sixteen-bit timer with prescaler, oscillator pins and power-mode status
// assumes an apb master on pclk; pins are outside the clock domain
`timescale 1ns/100ps
module sixteen_bit_timer_with_osc (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // oscillator pins: bit 0 osc_in_pin, bit 1 osc_out_ext_clock_pin
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe,
    output logic osc_amp_enable,
    // port logic sharing the pins
    input wire logic [1:0] port_direction,
    input wire logic [1:0] port_data_out,
    output logic [1:0] port_data_in,
    // power management
    input wire logic sleep_exec,
    input wire logic wake,
    input wire logic clock_monitor_enable,
    input wire logic osc_failed,
    output logic secondary_run_active,
    output logic secondary_idle_active,
    // interrupt request
    output logic overflow_irq
);
    logic [1:0] pin_level;
    logic [7:0] timer_control;
    logic [7:0] oscillator_control;
    logic [15:0] count;
    logic [7:0] high_buffer;
    logic [2:0] prescale_count;
    logic [1:0] instr_div;
    logic ext_level_prev;
    logic sync_pending;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic sysclk_status;
    timer_pkg::power_mode_type power_mode;

    logic [7:0] next_timer_control;
    logic [7:0] next_oscillator_control;
    logic [15:0] next_count;
    logic [7:0] next_high_buffer;
    logic [2:0] next_prescale_count;
    logic [1:0] next_instr_div;
    logic next_sync_pending;
    logic next_overflow_flag;
    logic next_overflow_irq_enable;
    logic next_sysclk_status;
    timer_pkg::power_mode_type next_power_mode;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [1:0] next_pin_oe;
    logic [1:0] next_port_data_in;

    logic instr_tick;
    logic ext_edge;
    logic source_tick;
    logic prescale_tick;
    logic count_inc;
    logic wrap;
    logic done;
    logic wr;
    logic rd;
    logic hit;
    logic [7:0] wbyte;

    function automatic logic [2:0] prescale_last(input logic [1:0] sel);
        prescale_last = 3'((4'h1 << sel) - 4'h1);
    endfunction

    pin_synchronizer #(
        .width(2)
    ) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_raw(pin_in),
        .level(pin_level)
    );

    // completed apb transfer
    always_comb
    begin
        done = psel & penable & pready;
        wr = done & pwrite;
        rd = done & ~pwrite;
        wbyte = pwdata[7:0];
        hit = (paddr == timer_pkg::addr_count_low)
            || (paddr == timer_pkg::addr_count_high)
            || (paddr == timer_pkg::addr_timer_control)
            || (paddr == timer_pkg::addr_oscillator_control)
            || (paddr == timer_pkg::addr_peripheral_flags)
            || (paddr == timer_pkg::addr_peripheral_enables);
    end

    // count sources and prescaler
    always_comb
    begin
        instr_tick = (instr_div == timer_pkg::instr_div_last);
        next_instr_div = instr_tick ? 2'h0 : instr_div + 2'h1;
        ext_edge = pin_level[1] & ~ext_level_prev;
        next_sync_pending = ext_edge | (sync_pending & ~instr_tick);
        if (!timer_control[timer_pkg::bit_clock_source_select])
        begin
            source_tick = instr_tick;
        end
        else if (timer_control[timer_pkg::bit_sync_bypass])
        begin
            source_tick = ext_edge;
        end
        else
        begin
            source_tick = sync_pending & instr_tick;
        end
        source_tick = source_tick & timer_control[timer_pkg::bit_run_enable];
        prescale_tick = source_tick && (prescale_count
            == prescale_last(timer_control[timer_pkg::bit_prescale_lo +: 2]));
        next_prescale_count = prescale_count;
        if (source_tick)
        begin
            next_prescale_count = prescale_tick ? 3'h0 : prescale_count + 3'h1;
        end
        if (wr && (paddr == timer_pkg::addr_count_low))
        begin
            next_prescale_count = 3'h0;
        end
        count_inc = prescale_tick;
        wrap = count_inc && (count == 16'hffff);
    end

    // registers, counter and flags
    always_comb
    begin
        next_timer_control = timer_control;
        next_oscillator_control = oscillator_control;
        next_high_buffer = high_buffer;
        next_overflow_irq_enable = overflow_irq_enable;
        next_count = count_inc ? count + 16'h0001 : count;
        next_overflow_flag = overflow_flag;
        if (wr && hit)
        begin
            unique case (paddr)
                timer_pkg::addr_count_low:
                begin
                    next_count[7:0] = wbyte;
                    if (timer_control[timer_pkg::bit_buffered_wide_access])
                    begin
                        next_count = {high_buffer, wbyte};
                    end
                end
                timer_pkg::addr_count_high:
                begin
                    if (timer_control[timer_pkg::bit_buffered_wide_access])
                    begin
                        next_high_buffer = wbyte;
                    end
                    else
                    begin
                        next_count[15:8] = wbyte;
                    end
                end
                timer_pkg::addr_timer_control:
                begin
                    next_timer_control = wbyte;
                    next_timer_control[timer_pkg::bit_sysclk_from_timer_osc] = 1'b0;
                end
                timer_pkg::addr_oscillator_control:
                begin
                    next_oscillator_control = wbyte;
                end
                timer_pkg::addr_peripheral_flags:
                begin
                    next_overflow_flag = wbyte[timer_pkg::bit_overflow];
                end
                timer_pkg::addr_peripheral_enables:
                begin
                    next_overflow_irq_enable = wbyte[timer_pkg::bit_overflow];
                end
            endcase
        end
        if (rd && (paddr == timer_pkg::addr_count_low)
            && timer_control[timer_pkg::bit_buffered_wide_access])
        begin
            next_high_buffer = count[15:8];
        end
        if (wrap)
        begin
            next_overflow_flag = 1'b1;
        end
    end

    // power modes and clock status
    always_comb
    begin
        next_power_mode = power_mode;
        unique case (power_mode)
            timer_pkg::primary_clock:
            begin
                if (oscillator_control[1:0] == timer_pkg::sysclk_select_timer_osc)
                begin
                    next_power_mode = timer_pkg::secondary_run;
                end
            end
            timer_pkg::secondary_run:
            begin
                if (oscillator_control[1:0] != timer_pkg::sysclk_select_timer_osc)
                begin
                    next_power_mode = timer_pkg::primary_clock;
                end
                else if (sleep_exec && !oscillator_control[timer_pkg::bit_idle_on_sleep])
                begin
                    next_power_mode = timer_pkg::secondary_idle;
                end
            end
            timer_pkg::secondary_idle:
            begin
                if (wake)
                begin
                    next_power_mode = timer_pkg::secondary_run;
                end
            end
            default:
            begin
                next_power_mode = timer_pkg::primary_clock;
            end
        endcase
        next_sysclk_status = (next_power_mode != timer_pkg::primary_clock)
            && timer_control[timer_pkg::bit_osc_enable]
            && !(clock_monitor_enable && osc_failed);
    end

    // pins and apb answer
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            next_pin_oe[i] = ~timer_control[timer_pkg::bit_osc_enable]
                & ~port_direction[i];
            next_port_data_in[i] = ~timer_control[timer_pkg::bit_osc_enable]
                & pin_level[i];
        end
        next_pready = psel & penable & ~pready;
        next_pslverr = psel & penable & ~pready & ~hit;
        next_prdata = 32'h0000_0000;
        if (psel && penable && !pready && !pwrite)
        begin
            unique case (paddr)
                timer_pkg::addr_count_low:
                    next_prdata[7:0] = count[7:0];
                timer_pkg::addr_count_high:
                    next_prdata[7:0] = timer_control[timer_pkg::bit_buffered_wide_access]
                        ? high_buffer : count[15:8];
                timer_pkg::addr_timer_control:
                begin
                    next_prdata[7:0] = timer_control;
                    next_prdata[timer_pkg::bit_sysclk_from_timer_osc] = sysclk_status;
                end
                timer_pkg::addr_oscillator_control:
                    next_prdata[7:0] = oscillator_control;
                timer_pkg::addr_peripheral_flags:
                    next_prdata[timer_pkg::bit_overflow] = overflow_flag;
                timer_pkg::addr_peripheral_enables:
                    next_prdata[timer_pkg::bit_overflow] = overflow_irq_enable;
                default:
                    next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer_control <= timer_pkg::timer_control_reset;
            oscillator_control <= timer_pkg::oscillator_control_reset;
            count <= timer_pkg::count_reset;
            high_buffer <= 8'h00;
            prescale_count <= 3'h0;
            instr_div <= 2'h0;
            ext_level_prev <= 1'b0;
            sync_pending <= 1'b0;
            overflow_flag <= 1'b0;
            overflow_irq_enable <= 1'b0;
            sysclk_status <= 1'b0;
            power_mode <= timer_pkg::primary_clock;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            pin_out <= 2'h0;
            pin_oe <= 2'h0;
            port_data_in <= 2'h0;
            osc_amp_enable <= 1'b0;
            secondary_run_active <= 1'b0;
            secondary_idle_active <= 1'b0;
            overflow_irq <= 1'b0;
        end
        else
        begin
            timer_control <= next_timer_control;
            oscillator_control <= next_oscillator_control;
            count <= next_count;
            high_buffer <= next_high_buffer;
            prescale_count <= next_prescale_count;
            instr_div <= next_instr_div;
            ext_level_prev <= pin_level[1];
            sync_pending <= next_sync_pending;
            overflow_flag <= next_overflow_flag;
            overflow_irq_enable <= next_overflow_irq_enable;
            sysclk_status <= next_sysclk_status;
            power_mode <= next_power_mode;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            pin_out <= port_data_out;
            pin_oe <= next_pin_oe;
            port_data_in <= next_port_data_in;
            osc_amp_enable <= next_timer_control[timer_pkg::bit_osc_enable];
            secondary_run_active <= (next_power_mode == timer_pkg::secondary_run);
            secondary_idle_active <= (next_power_mode == timer_pkg::secondary_idle);
            overflow_irq <= next_overflow_flag & next_overflow_irq_enable;
        end
    end
endmodule // sixteen_bit_timer_with_osc

/* File: rtl/timer_pkg.sv */
// constants for the sixteen-bit timer with its low-power oscillator
// assumes an apb master on pclk and a 40 MHz system clock
// Function
// - counter advances only while run_enable (control bit 0) is set
// - 16-bit count seen as read/write high and low byte registers
// - wrap from ffff to 0000 raises the overflow condition
// - clock_source_select clear counts each instruction cycle, pclk divided by four
// - clock_source_select set counts rising edges of pin or crystal oscillator
// - prescale_select bits 5:4 divide input by 1, 2, 4 or 8
// - sync_bypass 0 synchronizes the external clock, 1 counts it asynchronously
// - sync_bypass ignored when the internal clock is selected
// - osc_enable bit 3 runs the oscillator amplifier, off when clear
// - oscillator enabled forces both pins to inputs reading zero
// - read-only bit 6 shows the system clock comes from this oscillator
// - system_clock_select 01 enters secondary run from this oscillator
// - sleep with idle_on_sleep clear enters secondary idle
// - with clock monitor on, failed oscillator clears the status bit
// - oscillator keeps running through every power-managed mode
// - bit 7 selects buffered 16-bit access, else two 8-bit accesses
// - buffered mode: high address is a buffer, low read loads it
// - buffered mode: low write loads high byte from buffer together
// - only low byte writes clear the prescaler
// - overflow latches flag bit 0; irq only when enable bit 0 set
package timer_pkg;
    localparam logic [7:0] addr_count_low = 8'h00;
    localparam logic [7:0] addr_count_high = 8'h04;
    localparam logic [7:0] addr_timer_control = 8'h08;
    localparam logic [7:0] addr_oscillator_control = 8'h0c;
    localparam logic [7:0] addr_peripheral_flags = 8'h10;
    localparam logic [7:0] addr_peripheral_enables = 8'h14;

    localparam int bit_run_enable = 0;
    localparam int bit_clock_source_select = 1;
    localparam int bit_sync_bypass = 2;
    localparam int bit_osc_enable = 3;
    localparam int bit_prescale_lo = 4;
    localparam int bit_sysclk_from_timer_osc = 6;
    localparam int bit_buffered_wide_access = 7;
    localparam int bit_idle_on_sleep = 7;
    localparam int bit_overflow = 0;

    localparam logic [7:0] timer_control_reset = 8'h00;
    localparam logic [7:0] oscillator_control_reset = 8'h00;
    localparam logic [15:0] count_reset = 16'h0000;
    localparam logic [1:0] sysclk_select_timer_osc = 2'h1;

    localparam int clock_hz = 40000000;
    localparam int instr_cycle_hz = clock_hz / 4;
    localparam logic [1:0] instr_div_last = 2'((clock_hz / instr_cycle_hz) - 1);

    typedef enum logic [1:0] {
        primary_clock = 2'b00,
        secondary_run = 2'b01,
        secondary_idle = 2'b11
    } power_mode_type;
endpackage

/* File: rtl/pin_synchronizer.sv */
// three-stage synchronizer for asynchronous pin levels
// assumes a free-running pclk; output changes once stages two and three agree
`timescale 1ns/100ps
module pin_synchronizer #(
    parameter int width = 2
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pins and filtered level
    input wire logic [width-1:0] pin_raw,
    output logic [width-1:0] level
);
    logic [width-1:0] stage1;
    logic [width-1:0] stage2;
    logic [width-1:0] stage3;
    logic [width-1:0] next_level;

    always_comb
    begin
        for (int i = 0; i < width; i++)
        begin
            next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level <= '0;
        end
        else
        begin
            stage1 <= pin_raw;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= next_level;
        end
    end
endmodule // pin_synchronizer

/* File: tb/timer_checker.sv */
// assertions on the timer's apb, pin and power ports
// assumes it is bound to the timer top module
`timescale 1ns/100ps
module timer_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and power
    input wire logic [1:0] pin_oe,
    input wire logic osc_amp_enable,
    input wire logic [1:0] port_data_in,
    input wire logic sleep_exec,
    input wire logic secondary_run_active,
    input wire logic secondary_idle_active
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_ctl_osc_on;
        s_access ##0 (pready && pwrite && paddr == timer_pkg::addr_timer_control && pwdata[3]);
    endsequence
    property p_one_wait;
        s_setup ##1 s_access |=> pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("pready late");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
    property p_err_with_ready;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("bad error");
    property p_quiet_data;
        !pready |-> prdata == 32'h0;
    endproperty
    a_quiet_data: assert property (p_quiet_data) else $error("stray data");
    property p_byte_wide;
        pready |-> prdata[31:8] == 24'h0;
    endproperty
    a_byte_wide: assert property (p_byte_wide) else $error("upper bits set");
    property p_osc_pins;
        osc_amp_enable [*2] |-> pin_oe == 2'b00 && port_data_in == 2'b00;
    endproperty
    a_osc_pins: assert property (p_osc_pins) else $error("pins not inputs");
    property p_osc_on_write;
        s_ctl_osc_on |-> ##[1:2] osc_amp_enable;
    endproperty
    a_osc_on_write: assert property (p_osc_on_write) else $error("osc not on");
    property p_idle_entry;
        $rose(secondary_idle_active) |-> $past(sleep_exec) && $past(secondary_run_active);
    endproperty
    a_idle_entry: assert property (p_idle_entry) else $error("bad idle entry");
endmodule // timer_checker

/* File: tb/ext_clock_model.sv */
// external clock source on the shared clock pin
// assumes run is driven by the bench; line idles low between bursts
`timescale 1ns/100ps
module ext_clock_model #(
    parameter int half_ns = 100
) (
    input wire logic run,
    output logic clk_out
);
    initial clk_out = 1'b0;
    always
    begin
        wait (run === 1'b1);
        #(half_ns);
        if (run === 1'b1)
            clk_out = ~clk_out;
        else
            clk_out = 1'b0;
    end
endmodule // ext_clock_model

/* File: tb/tb.sv */
// self-checking bench for the sixteen-bit timer
// assumes the timer package and design files are compiled first
`timescale 1ns/100ps
module tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, osc_amp_enable, secondary_run_active, secondary_idle_active;
    logic overflow_irq, ext_clk;
    logic [1:0] pin_oe, pin_out, port_data_in;
    logic [1:0] port_direction = 2'b00, port_data_out = 2'b10;
    logic sleep_exec = 1'b0, wake = 1'b0, clock_monitor_enable = 1'b0, osc_failed = 1'b0;
    logic osc_in_level = 1'b1, ext_run = 1'b0;
    int n_mismatch = 0, check_count = 0;
    localparam logic [7:0] ctl = timer_pkg::addr_timer_control;
    localparam logic [7:0] lo = timer_pkg::addr_count_low;
    localparam logic [7:0] hi = timer_pkg::addr_count_high;
    always #12.5 pclk = ~pclk;
    ext_clock_model src (.run(ext_run), .clk_out(ext_clk));
    sixteen_bit_timer_with_osc dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in({ext_clk, osc_in_level}),
        .pin_out(pin_out), .pin_oe(pin_oe), .osc_amp_enable(osc_amp_enable),
        .port_direction(port_direction), .port_data_out(port_data_out),
        .port_data_in(port_data_in), .sleep_exec(sleep_exec), .wake(wake),
        .clock_monitor_enable(clock_monitor_enable), .osc_failed(osc_failed),
        .secondary_run_active(secondary_run_active),
        .secondary_idle_active(secondary_idle_active), .overflow_irq(overflow_irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_near(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp && got !== exp + 1 && got !== exp - 1)
        begin
            n_mismatch++;
            $display("Error at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h0, d}, r, e);
        chk(e, 1'b0);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, {24'h0, exp});
        chk(e, 1'b0);
    endtask
    task automatic count_run(input logic [7:0] c, input int cyc, input bit ext);
        logic [31:0] v;
        logic e;
        wr(ctl, 8'h00);
        wr(lo, 8'h00);
        wr(hi, 8'h00);
        wr(ctl, c);
        if (ext)
        begin
            @(posedge pclk);
            ext_run <= 1'b1;
            repeat (78) @(posedge pclk);
            ext_run <= 1'b0;
            repeat (10) @(posedge pclk);
        end
        else
            repeat (cyc - 4) @(posedge pclk);
        wr(ctl, 8'h00);
        apb(1'b0, lo, 32'h0, v, e);
        chk_near(v, 32'd20 >> ext);
        repeat (20) @(posedge pclk);
        rdc(lo, v[7:0]);
    endtask
    task automatic t_reset_map;
        logic [31:0] r;
        logic e;
        rdc(ctl, 8'h00);
        rdc(lo, 8'h00);
        apb(1'b0, 8'h18, 32'h0, r, e);
        chk(e, 1'b1);
        chk(r, 32'h0);
        wr(ctl, 8'h40);
        rdc(ctl, 8'h00);
        wr(lo, 8'h5a);
        wr(hi, 8'ha5);
        rdc(lo, 8'h5a);
        rdc(hi, 8'ha5);
    endtask
    task automatic t_counting;
        for (int i = 0; i < 4; i++)
            count_run({2'b00, 2'(i), 4'h1}, 80 << i, 1'b0);
        count_run(8'h05, 80, 1'b0);
        count_run(8'h03, 0, 1'b1);
        count_run(8'h07, 0, 1'b1);
    endtask
    task automatic t_overflow;
        wr(ctl, 8'h00);
        wr(timer_pkg::addr_peripheral_enables, 8'h01);
        wr(hi, 8'hff);
        wr(lo, 8'hfe);
        wr(ctl, 8'h01);
        repeat (20) @(posedge pclk);
        wr(ctl, 8'h00);
        rdc(hi, 8'h00);
        rdc(timer_pkg::addr_peripheral_flags, 8'h01);
        chk(overflow_irq, 1'b1);
        wr(timer_pkg::addr_peripheral_enables, 8'h00);
        repeat (2) @(posedge pclk);
        chk(overflow_irq, 1'b0);
        wr(timer_pkg::addr_peripheral_flags, 8'h00);
        rdc(timer_pkg::addr_peripheral_flags, 8'h00);
    endtask
    task automatic t_buffered;
        wr(ctl, 8'h80);
        wr(hi, 8'h12);
        wr(lo, 8'h34);
        wr(ctl, 8'h00);
        rdc(hi, 8'h12);
        wr(ctl, 8'h80);
        wr(hi, 8'h56);
        rdc(lo, 8'h34);
        rdc(hi, 8'h12);
        wr(ctl, 8'h00);
        rdc(hi, 8'h12);
    endtask
    task automatic t_osc_power;
        repeat (4) @(posedge pclk);
        chk(pin_oe, 2'b11);
        chk(port_data_in, 2'b01);
        chk(pin_out, port_data_out);
        wr(ctl, 8'h08);
        repeat (3) @(posedge pclk);
        chk(osc_amp_enable, 1'b1);
        chk(pin_oe, 2'b00);
        chk(port_data_in, 2'b00);
        repeat (50) @(posedge pclk);
        wr(timer_pkg::addr_oscillator_control, 8'h01);
        repeat (3) @(posedge pclk);
        chk(secondary_run_active, 1'b1);
        rdc(ctl, 8'h48);
        clock_monitor_enable <= 1'b1;
        osc_failed <= 1'b1;
        repeat (3) @(posedge pclk);
        rdc(ctl, 8'h08);
        osc_failed <= 1'b0;
        sleep_exec <= 1'b1;
        @(posedge pclk);
        sleep_exec <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(secondary_idle_active, 1'b1);
        chk(osc_amp_enable, 1'b1);
        wake <= 1'b1;
        @(posedge pclk);
        wake <= 1'b0;
        wr(timer_pkg::addr_oscillator_control, 8'h00);
        repeat (3) @(posedge pclk);
        rdc(ctl, 8'h08);
        wr(ctl, 8'h00);
        repeat (3) @(posedge pclk);
        chk(osc_amp_enable, 1'b0);
    endtask
    task automatic tally_and_finish;
        if (n_mismatch == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_reset_map();
        t_osc_power();
        t_counting();
        t_overflow();
        t_buffered();
        tally_and_finish();
    end
    initial
    begin
        repeat (30000) @(posedge pclk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule // tb
bind sixteen_bit_timer_with_osc timer_checker chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_oe(pin_oe),
    .osc_amp_enable(osc_amp_enable), .port_data_in(port_data_in), .sleep_exec(sleep_exec),
    .secondary_run_active(secondary_run_active),
    .secondary_idle_active(secondary_idle_active));
